// ==== src/spbasr_pkg.sv ====
package spbasr_pkg;

  localparam int unsigned REG_W   = 8;
  localparam int unsigned APB_DW  = 32;
  localparam int unsigned APB_AW  = 12;
  localparam int unsigned IDX_W   = 10;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BUF_P1  = 10'h18C;
  localparam logic [IDX_W-1:0] IDX_ADD_P1  = 10'h18D;
  localparam logic [IDX_W-1:0] IDX_MSK_P1  = 10'h18E;
  localparam logic [IDX_W-1:0] IDX_STAT_P1 = 10'h18F;
  localparam logic [IDX_W-1:0] IDX_BUF_P2  = 10'h196;
  localparam logic [IDX_W-1:0] IDX_ADD_P2  = 10'h197;
  localparam logic [IDX_W-1:0] IDX_MSK_P2  = 10'h198;
  localparam logic [IDX_W-1:0] IDX_STAT_P2 = 10'h199;

  localparam logic [REG_W-1:0] BUF_RST  = 8'h00;
  localparam logic [REG_W-1:0] ADD_RST  = 8'h00;
  localparam logic [REG_W-1:0] MSK_RST  = 8'hFF;

  // Status bit positions
  localparam int unsigned STAT_SMP   = 7;
  localparam int unsigned STAT_CKE   = 6;
  localparam int unsigned STAT_DA    = 5;
  localparam int unsigned STAT_STOP  = 4;
  localparam int unsigned STAT_START = 3;
  localparam int unsigned STAT_RW    = 2;
  localparam int unsigned STAT_UA    = 1;
  localparam int unsigned STAT_BF    = 0;

  // Address compare windows per match phase
  localparam logic [REG_W-1:0] MATCH7_BITS   = 8'hFE;
  localparam logic [REG_W-1:0] MATCH10H_BITS = 8'h06;
  localparam logic [REG_W-1:0] MATCH10L_BITS = 8'hFF;

  // Serial clock period is BAUD_MULT * (n + 1) clocks; ticks mark half periods
  localparam int unsigned BAUD_MULT = 4;
  localparam int unsigned BAUD_HALF = BAUD_MULT / 2;
  localparam logic [REG_W-1:0] DIV_MIN = 8'h03;

  typedef enum logic [2:0] {
    MODE_SPI_HOST,
    MODE_SPI_CLIENT,
    MODE_I2C_HOST,
    MODE_I2C_CLIENT7,
    MODE_I2C_CLIENT10
  } spbasr_mode_type;

  typedef enum logic [1:0] {
    APH_7BIT,
    APH_10_HIGH,
    APH_10_LOW
  } spbasr_aphase_type;

  // Events from the serial engine, same clock
  typedef struct packed {
    logic              rx_valid;
    logic [REG_W-1:0]  rx_data;
    logic              byte_done;
    logic              byte_is_data;
    logic              addr_valid;
    spbasr_aphase_type addr_phase;
    logic [REG_W-1:0]  addr_byte;
    logic              start;
    logic              stop;
    logic              nack;
    logic              ua_set;
    logic              buf_full;
  } spbasr_evt_type;

  // Controls toward the serial engine
  typedef struct packed {
    logic              tx_load;
    logic [REG_W-1:0]  tx_data;
    logic              sample_end;
    logic              slew_en;
    logic              launch_idle;
    logic              smbus_thr;
    logic              match_valid;
    logic              addr_match;
    logic              sclk_tick;
    logic              div_invalid;
  } spbasr_cfg_type;

  typedef struct packed {
    logic [REG_W:0]    cnt;
    logic              tick;
  } spbasr_div_type;

endpackage : spbasr_pkg

// ==== src/spbasr_baud_div.sv ====
`timescale 1ns/1ns
module spbasr_baud_div
  import spbasr_pkg::*;
#(
  parameter int unsigned P_W = REG_W
) (
  input  wire logic           i_clk,
  input  wire logic           i_resetn,
  input  wire logic           i_run,
  input  wire logic [P_W-1:0] i_divisor,
  output logic                o_tick
);

  typedef struct packed {
    logic [P_W:0] cnt;
    logic         tick;
  } spbasr_bdiv_type;

  spbasr_bdiv_type st_reg;
  spbasr_bdiv_type st_next;
  logic [P_W:0]    limit;

  // Half period is BAUD_HALF * (n + 1) clocks, counted 0 .. limit
  assign limit = P_W'(BAUD_HALF) * {1'b0, i_divisor} + (P_W + 1)'(BAUD_HALF - 1);

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!i_run) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= limit) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;

endmodule : spbasr_baud_div

// ==== src/spbasr_regs.sv ====
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module spbasr_regs
  import spbasr_pkg::*;
#(
  parameter logic [IDX_W-1:0] P_IDX_BUF  = IDX_BUF_P1,
  parameter logic [IDX_W-1:0] P_IDX_ADD  = IDX_ADD_P1,
  parameter logic [IDX_W-1:0] P_IDX_MSK  = IDX_MSK_P1,
  parameter logic [IDX_W-1:0] P_IDX_STAT = IDX_STAT_P1
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [APB_AW-1:0] i_paddr,
  input  wire logic [APB_DW-1:0] i_pwdata,
  output logic      [APB_DW-1:0] o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire spbasr_mode_type   i_mode,
  input  wire logic              i_port_enable,
  input  wire logic              i_clk_run,
  input  wire spbasr_evt_type    i_evt,
  output spbasr_cfg_type         o_cfg
);

  typedef struct packed {
    logic [REG_W-1:0]  buf_b;
    logic [REG_W-1:0]  add;
    logic [REG_W-1:0]  msk;
    logic              sample_phase;
    logic              cke;
    logic              da;
    logic              stop;
    logic              start;
    logic              rw;
    logic              ua;
    logic              bf;
    logic [APB_DW-1:0] prdata;
    logic              pready;
    logic              pslverr;
    spbasr_cfg_type    cfg;
  } spbasr_state_type;

  spbasr_state_type st_reg;
  spbasr_state_type st_next;

  logic             is_i2c;
  logic             is_client;
  logic             is_ten;
  logic             is_host;
  logic             is_spi;
  logic             setup_ph;
  logic             wr_fire;
  logic             hit_buf;
  logic             hit_add;
  logic             hit_msk;
  logic             hit_stat;
  logic             hit_any;
  logic             div_tick;
  logic             match_ok;
  logic             phase_ok;
  logic [REG_W-1:0] cmp_bits;
  logic [REG_W-1:0] stat_view;
  logic [REG_W-1:0] rd_byte;

  assign is_i2c    = (i_mode == MODE_I2C_HOST) || (i_mode == MODE_I2C_CLIENT7) || (i_mode == MODE_I2C_CLIENT10);
  assign is_client = (i_mode == MODE_I2C_CLIENT7) || (i_mode == MODE_I2C_CLIENT10);
  assign is_ten    = (i_mode == MODE_I2C_CLIENT10);
  assign is_host   = (i_mode == MODE_SPI_HOST) || (i_mode == MODE_I2C_HOST);
  assign is_spi    = (i_mode == MODE_SPI_HOST) || (i_mode == MODE_SPI_CLIENT);

  // APB decode: word aligned, index in the upper address bits
  assign setup_ph = i_psel && !i_penable;
  assign wr_fire  = i_psel && i_penable && st_reg.pready && i_pwrite;
  assign hit_buf  = (i_paddr[1:0] == 2'h0) && (i_paddr[APB_AW-1:2] == P_IDX_BUF);
  assign hit_add  = (i_paddr[1:0] == 2'h0) && (i_paddr[APB_AW-1:2] == P_IDX_ADD);
  assign hit_msk  = (i_paddr[1:0] == 2'h0) && (i_paddr[APB_AW-1:2] == P_IDX_MSK);
  assign hit_stat = (i_paddr[1:0] == 2'h0) && (i_paddr[APB_AW-1:2] == P_IDX_STAT);
  assign hit_any  = hit_buf || hit_add || hit_msk || hit_stat;

  spbasr_baud_div #(
    .P_W       (REG_W)
  ) u_baud_div (
    .i_clk     (i_clk),
    .i_resetn  (i_resetn),
    .i_run     (i_clk_run && is_host && i_port_enable),
    .i_divisor (st_reg.add),
    .o_tick    (div_tick)
  );

  // Client address compare window by phase
  always_comb begin
    cmp_bits = MATCH7_BITS;
    phase_ok = 1'b0;
    case (i_evt.addr_phase)
      APH_7BIT: begin
        cmp_bits = MATCH7_BITS;
        phase_ok = (i_mode == MODE_I2C_CLIENT7);
      end
      APH_10_HIGH: begin
        cmp_bits = MATCH10H_BITS;
        phase_ok = is_ten;
      end
      APH_10_LOW: begin
        cmp_bits = MATCH10L_BITS;
        phase_ok = is_ten;
      end
      default: begin
        cmp_bits = MATCH7_BITS;
        phase_ok = 1'b0;
      end
    endcase
  end

  assign match_ok = phase_ok && (((i_evt.addr_byte ^ st_reg.add) & st_reg.msk & cmp_bits) == '0);

  // Status as read; bits reserved in the current mode read zero
  always_comb begin
    stat_view             = '0;
    stat_view[STAT_SMP]   = st_reg.sample_phase;
    stat_view[STAT_CKE]   = st_reg.cke;
    stat_view[STAT_DA]    = st_reg.da && is_client;
    stat_view[STAT_STOP]  = st_reg.stop && is_i2c;
    stat_view[STAT_START] = st_reg.start && is_i2c;
    stat_view[STAT_RW]    = st_reg.rw && is_client;
    stat_view[STAT_UA]    = st_reg.ua && is_ten;
    stat_view[STAT_BF]    = st_reg.bf;
  end

  always_comb begin
    rd_byte = '0;
    if (hit_buf) begin
      rd_byte = st_reg.buf_b;
    end else if (hit_add) begin
      rd_byte = st_reg.add;
    end else if (hit_msk) begin
      rd_byte = st_reg.msk;
    end else if (hit_stat) begin
      rd_byte = stat_view;
    end
  end

  always_comb begin
    st_next             = st_reg;
    st_next.cfg.tx_load = 1'b0;
    st_next.cfg.match_valid = 1'b0;

    // Answer prepared in setup, presented in the first access cycle
    st_next.pready = setup_ph;
    if (setup_ph) begin
      st_next.prdata  = {{(APB_DW-REG_W){1'b0}}, rd_byte};
      st_next.pslverr = !hit_any;
    end

    if (wr_fire && hit_buf) begin
      st_next.buf_b       = i_pwdata[REG_W-1:0];
      st_next.cfg.tx_load = 1'b1;
    end
    if (i_evt.rx_valid) begin
      st_next.buf_b = i_evt.rx_data;
    end
    if (wr_fire && hit_add) begin
      st_next.add = i_pwdata[REG_W-1:0];
      st_next.ua  = 1'b0;
    end
    if (wr_fire && hit_msk) begin
      st_next.msk = i_pwdata[REG_W-1:0];
    end
    if (wr_fire && hit_stat) begin
      st_next.sample_phase = i_pwdata[STAT_SMP];
      st_next.cke = i_pwdata[STAT_CKE];
    end

    // Hardware-set flags; a set in the same cycle beats a software clear, but stop beats start and port disable clears all but bf
    if (i_evt.ua_set) begin
      st_next.ua = 1'b1;
    end
    if (i_evt.byte_done) begin
      st_next.da = i_evt.byte_is_data;
    end
    if (i_evt.start) begin
      st_next.start = 1'b1;
      st_next.stop  = 1'b0;
    end
    if (i_evt.stop) begin
      st_next.stop  = 1'b1;
      st_next.start = 1'b0;
    end
    if (i_evt.start || i_evt.stop || i_evt.nack) begin
      st_next.rw = 1'b0;
    end
    if (i_evt.addr_valid) begin
      st_next.cfg.match_valid = 1'b1;
      st_next.cfg.addr_match  = match_ok;
      if (match_ok && (i_evt.addr_phase != APH_10_LOW)) begin
        st_next.rw = i_evt.addr_byte[0];
      end
    end
    st_next.bf = i_evt.buf_full;

    if (!i_port_enable) begin
      st_next.start = 1'b0;
      st_next.stop  = 1'b0;
      st_next.da    = 1'b0;
      st_next.rw    = 1'b0;
      st_next.ua    = 1'b0;
    end

    st_next.cfg.tx_data     = st_next.buf_b;
    st_next.cfg.sample_end  = (i_mode == MODE_SPI_HOST) && st_next.sample_phase;
    st_next.cfg.slew_en     = is_i2c && !st_next.sample_phase;
    st_next.cfg.launch_idle = is_spi && st_next.cke;
    st_next.cfg.smbus_thr   = is_i2c && st_next.cke;
    st_next.cfg.sclk_tick   = div_tick;
    st_next.cfg.div_invalid = is_host && (st_next.add < DIV_MIN);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg       <= '0;
      st_reg.buf_b <= BUF_RST;
      st_reg.add   <= ADD_RST;
      st_reg.msk   <= MSK_RST;
      st_reg.cfg.slew_en <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_prdata  = st_reg.prdata;
  assign o_pready  = st_reg.pready;
  assign o_pslverr = st_reg.pslverr;
  assign o_cfg     = st_reg.cfg;

  // Helper: cycles since the last serial clock tick
  logic [REG_W+2:0] tick_gap_reg;
  logic             tick_seen_reg;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_gap_reg  <= '0;
      tick_seen_reg <= 1'b0;
    end else if (!(i_clk_run && is_host && i_port_enable) || wr_fire) begin
      tick_gap_reg  <= '0;
      tick_seen_reg <= 1'b0;
    end else if (o_cfg.sclk_tick) begin
      tick_gap_reg  <= (REG_W+3)'(1);
      tick_seen_reg <= 1'b1;
    end else begin
      tick_gap_reg  <= tick_gap_reg + 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_buf_write: assert property (wr_fire && hit_buf && !i_evt.rx_valid |=>
    (st_reg.buf_b == $past(i_pwdata[REG_W-1:0])) && o_cfg.tx_load ##1 o_cfg.tx_data == st_reg.buf_b)
    else $error("buffer write not taken");
  a_baud_period: assert property (tick_seen_reg && o_cfg.sclk_tick |->
    tick_gap_reg == (REG_W+3)'(BAUD_HALF) * ({3'b000, st_reg.add} + 1'b1))
    else $error("serial clock half period wrong");
  a_hi_match: assert property (i_evt.addr_valid && is_ten && i_evt.addr_phase == APH_10_HIGH |=>
    o_cfg.addr_match == ((($past(i_evt.addr_byte) ^ $past(st_reg.add)) & $past(st_reg.msk) & MATCH10H_BITS) == '0))
    else $error("high address byte compare wrong");
  a_lo_match: assert property (i_evt.addr_valid && is_ten && i_evt.addr_phase == APH_10_LOW |=>
    o_cfg.addr_match == ((($past(i_evt.addr_byte) ^ $past(st_reg.add)) & $past(st_reg.msk)) == '0))
    else $error("low address byte compare wrong");
  a_seven_match: assert property (i_evt.addr_valid && i_mode == MODE_I2C_CLIENT7 &&
    i_evt.addr_phase == APH_7BIT && (i_evt.addr_byte[REG_W-1:1] == st_reg.add[REG_W-1:1]) |=> o_cfg.addr_match)
    else $error("seven bit address missed");
  a_mask_drop: assert property (i_evt.addr_valid && i_mode == MODE_I2C_CLIENT7 &&
    i_evt.addr_phase == APH_7BIT && st_reg.msk[REG_W-1:1] == '0 |=> o_cfg.addr_match && o_cfg.match_valid)
    else $error("fully masked address did not match");
  a_mask_zero: assert property (i_evt.addr_valid && i_mode == MODE_I2C_CLIENT7 &&
    i_evt.addr_phase == APH_7BIT && (i_evt.addr_byte[0] != st_reg.add[0]) &&
    (((i_evt.addr_byte ^ st_reg.add) & st_reg.msk & MATCH7_BITS) == '0) |=> o_cfg.addr_match)
    else $error("bit zero used in seven bit mode");
  a_sample_phase: assert property (i_mode == MODE_SPI_HOST && $stable(i_mode) |=>
    o_cfg.sample_end == st_reg.sample_phase)
    else $error("sample phase not applied");
  a_slew_ctrl: assert property (is_i2c && $stable(i_mode) |=> o_cfg.slew_en == !st_reg.sample_phase)
    else $error("slew control wrong");
  a_clk_edge: assert property (is_spi && $stable(i_mode) |=> o_cfg.launch_idle == st_reg.cke)
    else $error("launch edge wrong");
  a_smbus_thr: assert property (is_i2c && $stable(i_mode) |=> o_cfg.smbus_thr == st_reg.cke)
    else $error("thresholds select wrong");
  a_data_addr: assert property (i_evt.byte_done && i_port_enable |=> st_reg.da == $past(i_evt.byte_is_data))
    else $error("data/address flag wrong");
  a_stop_seen: assert property (i_evt.stop && i_port_enable |=> st_reg.stop && !st_reg.start)
    else $error("stop flag not set");
  a_start_seen: assert property (i_evt.start && !i_evt.stop && i_port_enable |=>
    st_reg.start && !st_reg.stop)
    else $error("start flag not set");
  a_rw_hold: assert property (i_evt.addr_valid && match_ok && i_evt.addr_phase == APH_7BIT && i_port_enable |=>
    st_reg.rw == $past(i_evt.addr_byte[0]))
    else $error("direction not captured");
  a_disable_clr: assert property (!i_port_enable |=> !st_reg.start && !st_reg.stop)
    else $error("flags survive disable");
  a_ua_flag: assert property (i_evt.ua_set && i_port_enable |=> st_reg.ua ##0
    (is_ten == stat_view[STAT_UA]))
    else $error("update address not flagged");
  a_ro_bits: assert property (wr_fire && hit_stat && !i_evt.start && !i_evt.stop && !i_evt.nack &&
    !i_evt.byte_done && !i_evt.addr_valid && !i_evt.ua_set && i_port_enable |=>
    $stable({st_reg.da, st_reg.stop, st_reg.start, st_reg.rw, st_reg.ua}) && st_reg.sample_phase == $past(i_pwdata[STAT_SMP]))
    else $error("read-only status bits changed");
  a_div_flag: assert property (is_host |=> o_cfg.div_invalid == (st_reg.add < DIV_MIN))
    else $error("divider range flag wrong");
  a_div_client: assert property (!is_host |=> !o_cfg.div_invalid)
    else $error("divider flag raised outside host mode");
  a_rw_clear: assert property (i_evt.nack && !i_evt.addr_valid |=>
    !st_reg.rw)
    else $error("direction kept after not-acknowledge");

  c_buf_write: cover property (wr_fire && hit_buf ##1 o_cfg.tx_load);
  c_addr_match: cover property (i_evt.addr_valid && is_ten ##1 o_cfg.addr_match);
  c_stop_after_start: cover property (i_evt.start ##[1:20] i_evt.stop);
  c_baud_ticks: cover property (o_cfg.sclk_tick ##[1:40] o_cfg.sclk_tick);
  c_rw_nack: cover property (st_reg.rw ##1 i_evt.nack ##1 !st_reg.rw);

endmodule : spbasr_regs

// ==== tb/spbasr_engine_model.sv ====
`timescale 1ns/1ns
module spbasr_engine_model
  import spbasr_pkg::*;
(
  input  wire logic           i_clk,
  input  wire spbasr_cfg_type i_cfg,
  output spbasr_evt_type      o_evt
);
  logic [REG_W-1:0] tx_seen = '0;

  initial begin
    o_evt = '0;
  end

  // Byte that software last handed to the line
  always @(posedge i_clk) begin
    if (i_cfg.tx_load === 1'b1) begin
      tx_seen <= i_cfg.tx_data;
    end
  end

  // One-cycle event; entered just after a rising edge
  task automatic pulse(input spbasr_evt_type e);
    begin
      o_evt <= e;
      @(posedge i_clk);
      o_evt <= '0;
    end
  endtask : pulse

endmodule : spbasr_engine_model

// ==== tb/serial_port_buffer_addr_status_regs_test.sv ====
`timescale 1ns/1ns
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module serial_port_buffer_addr_status_regs_test
  import spbasr_pkg::*;
;
  typedef struct packed {
    spbasr_mode_type   m;
    spbasr_aphase_type ph;
    logic [7:0]        add;
    logic [7:0]        msk;
    logic [7:0]        byt;
    logic              exp;
  } spbasr_mcase_type;

  localparam int EV_START = 0, EV_STOP = 1, EV_NACK = 2, EV_BYTE = 3, EV_UA = 4, EV_RX = 5, EV_ADDR = 6;

  logic              clk;
  logic              resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata;
  logic [APB_DW-1:0] prdata;
  logic              pready;
  logic              pslverr;
  spbasr_mode_type   mode;
  logic              port_en;
  logic              clk_run;
  spbasr_evt_type    evt;
  spbasr_cfg_type    cfg;
  wire  [3:0]        cfg_lines = {cfg.sample_end, cfg.slew_en, cfg.launch_idle, cfg.smbus_thr};
  int unsigned       miscompares = 0;
  int unsigned       num_checks  = 0;
  logic [31:0]       rd;
  logic              err;
  logic              spi;
  int                gap;
  logic [7:0]        divs [2] = '{8'h03, 8'h13};
  spbasr_mcase_type  mtab [9] = '{
    '{MODE_I2C_CLIENT7, APH_7BIT, 8'hA0, 8'hFF, 8'hA1, 1'b1},
    '{MODE_I2C_CLIENT7, APH_7BIT, 8'hA0, 8'hFF, 8'hA3, 1'b0},
    '{MODE_I2C_CLIENT7, APH_7BIT, 8'hA0, 8'hFD, 8'hA3, 1'b1},
    '{MODE_I2C_CLIENT7, APH_7BIT, 8'hA1, 8'hFE, 8'hA0, 1'b1},
    '{MODE_I2C_CLIENT10, APH_10_HIGH, 8'h01, 8'hFF, 8'hF0, 1'b1},
    '{MODE_I2C_CLIENT10, APH_10_HIGH, 8'h04, 8'hFF, 8'hF0, 1'b0},
    '{MODE_I2C_CLIENT10, APH_10_LOW, 8'h5A, 8'hFF, 8'h5B, 1'b0},
    '{MODE_I2C_CLIENT10, APH_10_LOW, 8'h5A, 8'hFE, 8'h5B, 1'b1},
    '{MODE_I2C_CLIENT10, APH_10_LOW, 8'h5A, 8'hFF, 8'h5A, 1'b1}};

  spbasr_regs uut (
    .i_clk         (clk),
    .i_resetn      (resetn),
    .i_psel        (psel),
    .i_penable     (penable),
    .i_pwrite      (pwrite),
    .i_paddr       (paddr),
    .i_pwdata      (pwdata),
    .o_prdata      (prdata),
    .o_pready      (pready),
    .o_pslverr     (pslverr),
    .i_mode        (mode),
    .i_port_enable (port_en),
    .i_clk_run     (clk_run),
    .i_evt         (evt),
    .o_cfg         (cfg)
  );

  spbasr_engine_model em (
    .i_clk                    (clk),
    .i_cfg                    (cfg),
    .o_evt                    (evt)
  );

  always #5 clk = ~clk;

  task automatic tally_and_finish();
    begin
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask : tally_and_finish

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        miscompares++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : check_val

  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    int n;
    begin
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h00_0000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
        miscompares++;
        tally_and_finish();
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next setup never lands in this time step
      @(posedge clk);
    end
  endtask : apb

  task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    begin
      apb(1'b0, idx, 8'h00);
      `CHK(rd, {24'h00_0000, exp});
      `CHK(err, 1'b0);
    end
  endtask : rdchk

  task automatic fire(input int k, input logic [7:0] b, input spbasr_aphase_type ph);
    spbasr_evt_type e;
    begin
      e = '0;
      case (k)
        EV_START: e.start = 1'b1;
        EV_STOP:  e.stop = 1'b1;
        EV_NACK:  e.nack = 1'b1;
        EV_BYTE:  begin
          e.byte_done    = 1'b1;
          e.byte_is_data = b[0];
        end
        EV_UA:    e.ua_set = 1'b1;
        EV_RX:    begin
          e.rx_valid = 1'b1;
          e.rx_data  = b;
        end
        default:  begin
          e.addr_valid = 1'b1;
          e.addr_phase = ph;
          e.addr_byte  = b;
        end
      endcase
      em.pulse(e);
    end
  endtask : fire

  // Edges between two half-period ticks, second gap after a change
  task automatic meas_gap();
    begin
      repeat (2) begin
        gap = 0;
        do begin
          @(posedge clk);
          gap++;
        end while (cfg.sclk_tick !== 1'b1 && gap < 100);
        if (cfg.sclk_tick !== 1'b1) begin
          miscompares++;
          tally_and_finish();
        end
      end
    end
  endtask : meas_gap

  initial begin
    clk     = 1'b0;
    resetn  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    mode    = MODE_I2C_CLIENT7;
    port_en = 1'b1;
    clk_run = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdchk(IDX_BUF_P1, 8'h00);
    rdchk(IDX_ADD_P1, 8'h00);
    rdchk(IDX_MSK_P1, 8'hFF);
    rdchk(IDX_STAT_P1, 8'h00);
    $display("Test reset values done");
    apb(1'b1, IDX_BUF_P1, 8'hA5);
    `CHK({cfg.tx_load, cfg.tx_data}, 9'h1A5);
    rdchk(IDX_BUF_P1, 8'hA5);
    `CHK(em.tx_seen, 8'hA5);
    fire(EV_RX, 8'h3C, APH_7BIT);
    rdchk(IDX_BUF_P1, 8'h3C);
    apb(1'b1, 10'h190, 8'h77);
    `CHK(err, 1'b1);
    rdchk(IDX_BUF_P1, 8'h3C);
    $display("Test data buffer done");
    apb(1'b1, IDX_STAT_P1, 8'hFF);
    rdchk(IDX_STAT_P1, 8'hC0);
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, IDX_STAT_P1, {s[0], s[0], 6'h00});
      for (int m = 0; m < 5; m++) begin
        if (s == 1 && m == 1) continue;
        mode <= spbasr_mode_type'(m);
        repeat (2) @(posedge clk);
        spi = (m < 2);
        `CHK(cfg_lines, {s[0] && m == 0, !spi && !s[0], spi && s[0], !spi && s[0]});
        `CHK(cfg.div_invalid, m == 0 || m == 2);
      end
    end
    $display("Test sample and edge bits done");
    mode    <= MODE_SPI_HOST;
    clk_run <= 1'b1;
    foreach (divs[i]) begin
      apb(1'b1, IDX_ADD_P1, divs[i]);
      meas_gap();
      `CHK(gap, BAUD_MULT * (divs[i] + 1) / 2);
    end
    `CHK(cfg.div_invalid, 1'b0);
    clk_run <= 1'b0;
    $display("Test baud divider done");
    foreach (mtab[i]) begin
      mode <= mtab[i].m;
      apb(1'b1, IDX_ADD_P1, mtab[i].add);
      apb(1'b1, IDX_MSK_P1, mtab[i].msk);
      fire(EV_ADDR, mtab[i].byt, mtab[i].ph);
      @(posedge clk);
      `CHK({cfg.match_valid, cfg.addr_match}, {1'b1, mtab[i].exp});
    end
    rdchk(IDX_ADD_P1, 8'h5A);
    rdchk(IDX_MSK_P1, 8'hFF);
    $display("Test address match done");
    mode <= MODE_I2C_CLIENT7;
    apb(1'b1, IDX_ADD_P1, 8'hA0);
    fire(EV_ADDR, 8'hA1, APH_7BIT);
    rdchk(IDX_STAT_P1, 8'h04);
    fire(EV_NACK, 8'h00, APH_7BIT);
    rdchk(IDX_STAT_P1, 8'h00);
    fire(EV_ADDR, 8'hA1, APH_7BIT);
    rdchk(IDX_STAT_P1, 8'h04);
    fire(EV_START, 8'h00, APH_7BIT);
    rdchk(IDX_STAT_P1, 8'h08);
    fire(EV_BYTE, 8'h01, APH_7BIT);
    rdchk(IDX_STAT_P1, 8'h28);
    fire(EV_STOP, 8'h00, APH_7BIT);
    @(posedge clk);
    fire(EV_BYTE, 8'h00, APH_7BIT);
    rdchk(IDX_STAT_P1, 8'h10);
    port_en <= 1'b0;
    repeat (2) @(posedge clk);
    rdchk(IDX_STAT_P1, 8'h00);
    port_en <= 1'b1;
    $display("Test status flags done");
    mode <= MODE_I2C_CLIENT10;
    fire(EV_UA, 8'h00, APH_7BIT);
    rdchk(IDX_STAT_P1, 8'h02);
    apb(1'b1, IDX_ADD_P1, 8'h00);
    rdchk(IDX_STAT_P1, 8'h00);
    $display("Test update address done");
    tally_and_finish();
  end

endmodule : serial_port_buffer_addr_status_regs_test
